// File: pstl_blink.sv
`timescale 1ns/1ns
module pstl_blink #(
    parameter int unsigned HALF = 10
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // Control and output
    input  wire logic run_i,
    output logic      blink_o,
    output logic      fall_o
);
    localparam int unsigned CW = $clog2(HALF + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF - 1);

    logic [CW-1:0] cnt_q;
    logic          wrap;

    // End of a half period
    assign wrap   = run_i & (cnt_q == LAST);
    assign fall_o = wrap & blink_o;

    // Square wave while running, dark otherwise
    always_ff @(posedge clk_i) begin
        if (!rstn_i || !run_i) begin
            cnt_q   <= '0;
            blink_o <= 1'b0;
        end else if (wrap) begin
            cnt_q   <= '0;
            blink_o <= ~blink_o;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end
endmodule : pstl_blink

// File: pstl_ctrl_model.sv
`timescale 1ns/1ns
module pstl_ctrl_model
    import pstl_pkg::*;
#(
    parameter int unsigned SETTLE = 15
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // Device outputs
    input  wire logic        sw_i,
    input  wire pstl_ana_s   ana_i,
    // Accepted values
    output logic             sw_o,
    output logic      [15:0] code_o
);
    int unsigned wait_q;

    // inactive analogue line reads as zero
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wait_q <= 0;
            sw_o   <= 1'h0;
            code_o <= 16'h0000;
        end else if (wait_q < SETTLE) begin
            wait_q <= wait_q + 1;
        end else begin
            sw_o   <= sw_i;
            code_o <= ana_i.active ? ana_i.code : 16'h0000;
        end
    end
endmodule : pstl_ctrl_model

// File: pstl_pkg.sv
package pstl_pkg;
// Summary of operation
// [R1] Error LED blinks 4 Hz on fault
// [R2] Overcurrent lights its own indicator
// [R3] Indicator shows magnet inside measuring range
// [R4] Distinct indicator when magnet outside range
// [R5] Analogue output off in serial link mode
// [R6] Defaults: switch low, current, full range
// [R7] Click then hold enters teach, slow blink
// [R8] Operator waits before retrying double click
// [R9] Completed teach acknowledged by four blinks
// [R10] Missing magnet aborts teach, four orange blinks
// [R11] Range shorter than minimum span rejected
// [R12] Range reset restores full span
// [R13] Current or voltage analogue output selectable
// [R14] Analogue characteristic can be inverted
// [R15] Four switch evaluation modes offered
// [R16] Points plus or minus hysteresis stay inside; point writes are taken unchecked
// [R17] Auto mode band around point, margins checked
// [R18] Window hysteresis below point distance; hysteresis writes check only HYST_MIN and HYST_MAX
// [R19] Two point only by link, kept afterwards
// [R20] Hysteresis default 0.5 mm, 0.05 to 20
// [R21] Startup outside range: outputs low until stroke
// [R22] Controller ignores outputs shortly after power
// [R23] Single point sets at point, clears below
// [R24] Window mode with hysteresis at both edges

    // Clock and derived cycle counts
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned MS_CYC        = CLK_HZ / 1000;
    localparam int unsigned ERR_HZ        = 4;
    localparam int unsigned ERR_HALF_CYC  = CLK_HZ / (2 * ERR_HZ);
    localparam int unsigned SLOW_HALF_MS  = 500;
    localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_MS * MS_CYC;
    localparam int unsigned ACK_HALF_MS   = 100;
    localparam int unsigned ACK_HALF_CYC  = ACK_HALF_MS * MS_CYC;
    localparam int unsigned CLICK_MAX_MS  = 500;
    localparam int unsigned CLICK_MAX_CYC = CLICK_MAX_MS * MS_CYC;
    localparam int unsigned HOLD_MIN_MS   = 1000;
    localparam int unsigned HOLD_MIN_CYC  = HOLD_MIN_MS * MS_CYC;
    localparam int unsigned TMR_W         = 27;

    // Lengths in units of 0.01 mm
    localparam logic [15:0] HYST_RST  = 16'h0032;
    localparam logic [15:0] HYST_MIN  = 16'h0005;
    localparam logic [15:0] HYST_MAX  = 16'h07D0;
    localparam logic [15:0] MIN_SPAN  = 16'h0064;
    localparam logic [15:0] AUTO_BAND = 16'h0096;
    localparam logic [15:0] PT1_RST   = 16'h03E8;
    localparam logic [15:0] PT2_RST   = 16'h07D0;
    localparam logic [15:0] SPAN_RST  = 16'h2710;
    localparam logic [2:0]  ACK_BLINKS = 3'h4;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_PT1    = 8'h04;
    localparam logic [7:0] REG_PT2    = 8'h08;
    localparam logic [7:0] REG_HYST   = 8'h0C;
    localparam logic [7:0] REG_RSTART = 8'h10;
    localparam logic [7:0] REG_REND   = 8'h14;
    localparam logic [7:0] REG_STAT   = 8'h18;
    localparam logic [7:0] REG_ANA    = 8'h1C;

    // Control register bit positions
    localparam int CB_VOLT      = 0;
    localparam int CB_INV       = 1;
    localparam int CB_MODE      = 2;
    localparam int CB_SERIAL    = 4;
    localparam int CB_RANGE_RST = 8;
    localparam int CB_FACTORY   = 9;
    localparam int CB_T_START   = 10;
    localparam int CB_T_END     = 11;

    typedef enum logic [1:0] {
        MD_SINGLE, MD_AUTO, MD_WINDOW, MD_TWO
    } pstl_mode_e;

    typedef enum logic [2:0] {
        TS_IDLE, TS_PRESS, TS_GAP, TS_HOLD, TS_LVL1, TS_LVL2
    } pstl_teach_e;

    typedef struct packed {
        logic        active;
        logic        volt;
        logic [15:0] code;
    } pstl_ana_s;

    typedef struct packed {
        logic link;
        logic cur;
        logic volt;
        logic err;
        logic high;
        logic low;
        logic ovc;
        logic inr;
        logic outr;
        logic teach;
        logic orange;
    } pstl_led_s;

endpackage : pstl_pkg

// File: pstl_sync.sv
`timescale 1ns/1ns
module pstl_sync #(
    parameter int unsigned W = 2
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    // Asynchronous in, synchronous out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    // Two-stage synchroniser
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule : pstl_sync

// File: pstl_top.sv
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module pstl_top
    import pstl_pkg::*;
#(
    parameter int unsigned ERR_HALF  = ERR_HALF_CYC,
    parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
    parameter int unsigned ACK_HALF  = ACK_HALF_CYC,
    parameter int unsigned CLICK_MAX = CLICK_MAX_CYC,
    parameter int unsigned HOLD_MIN  = HOLD_MIN_CYC,
    parameter logic [15:0] FULL_SPAN = SPAN_RST
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // Internal sensing
    input  wire logic [15:0] pos_i,
    input  wire logic        mag_ok_i,
    input  wire logic        ready_i,
    input  wire logic        field_weak_i,
    // Pins
    input  wire logic        pad_i,
    input  wire logic        ovc_i,
    // Outputs
    output logic             sw_o,
    output pstl_ana_s        ana_o,
    output pstl_led_s        led_o
);
    localparam logic [TMR_W-1:0] CLICK_W = TMR_W'(CLICK_MAX);
    localparam logic [TMR_W-1:0] HOLD_W  = TMR_W'(HOLD_MIN);

    function automatic logic [15:0] sub_sat(input logic [15:0] a,
                                            input logic [15:0] b);
        sub_sat = (a > b) ? a - b : 16'h0000;
    endfunction : sub_sat

    logic             pad_s, ovc_s, pad_q;
    logic             wr_q;
    logic [7:0]       wa_q;
    logic [31:0]      rmux;
    logic             volt_q, inv_q, serial_q;
    pstl_mode_e       mode_q;
    logic [15:0]      pt1_q, pt2_q, hyst_q;
    logic [15:0]      start_q, end_q, tstart_q;
    logic             hold_q, first_q, seen_lo_q, seen_hi_q;
    logic             mag_in;
    logic             sw_q, sw_eval;
    pstl_ana_s        ana_d;
    pstl_led_s        led_d;
    pstl_teach_e      tst_q, tst_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic             load_st, commit, abort;
    logic [2:0]       ack_cnt_q;
    logic             ack_org_q;
    logic             err_bl, slow_bl, ack_bl, ack_fall;

    // Pin synchronisers
    pstl_sync #(.W(2)) u_sync (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .d_i    ({pad_i, ovc_i}),
        .q_o    ({pad_s, ovc_s})
    );

    // Bus decode
    wire        acc   = hsel_i & htrans_i[1] & hready_i;
    wire [7:0]  ra    = haddr_i[7:0];
    wire [15:0] wd16  = hwdata_i[15:0];
    wire        w_ctrl = wr_q & (wa_q == REG_CTRL);
    wire        w_pt1  = wr_q & (wa_q == REG_PT1);
    wire        w_pt2  = wr_q & (wa_q == REG_PT2);
    wire        w_hyst = wr_q & (wa_q == REG_HYST);
    wire        cmd_fac = w_ctrl & hwdata_i[CB_FACTORY];
    wire        cmd_rr  = w_ctrl & hwdata_i[CB_RANGE_RST];
    wire        cmd_ts  = w_ctrl & hwdata_i[CB_T_START];
    wire        cmd_te  = w_ctrl & hwdata_i[CB_T_END];
    wire [1:0]  wmode   = hwdata_i[CB_MODE+1:CB_MODE];
    // [R19] Two point only with link
    wire        mode_ok = (wmode != MD_TWO) | hwdata_i[CB_SERIAL];
    // [R20] Hysteresis window check
    wire        hyst_ok = (wd16 >= HYST_MIN) && (wd16 <= HYST_MAX);

    // Address and data phase capture
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wr_q     <= 1'b0;
            wa_q     <= 8'h00;
            hrdata_o <= 32'h0000_0000;
        end else begin
            wr_q <= acc & hwrite_i;
            if (acc)
                wa_q <= ra;
            if (acc & ~hwrite_i)
                hrdata_o <= rmux;
        end
    end

    // Zero wait state, always OKAY
    always_ff @(posedge clk_i) begin
        hreadyout_o <= 1'b1;
        hresp_o     <= 1'b0;
    end

    // Read selection
    always_comb begin
        if (ra == REG_CTRL)
            rmux = {27'h0, serial_q, mode_q, inv_q, volt_q};
        else if (ra == REG_PT1)
            rmux = {16'h0000, pt1_q};
        else if (ra == REG_PT2)
            rmux = {16'h0000, pt2_q};
        else if (ra == REG_HYST)
            rmux = {16'h0000, hyst_q};
        else if (ra == REG_RSTART)
            rmux = {16'h0000, start_q};
        else if (ra == REG_REND)
            rmux = {16'h0000, end_q};
        else if (ra == REG_STAT)
            rmux = {pos_i, 8'h00, tst_q, hold_q, ~ready_i | field_weak_i,
                    ovc_s, sw_q, mag_in};
        else if (ra == REG_ANA)
            rmux = {14'h0, ana_o.active, ana_o.volt, ana_o.code};
        else
            rmux = 32'h0000_0000;
    end

    // Link state follows software
    always_ff @(posedge clk_i) begin
        if (!rstn_i)
            serial_q <= 1'b0;
        else if (w_ctrl)
            serial_q <= hwdata_i[CB_SERIAL];
    end

    // Configuration; factory restore wins
    always_ff @(posedge clk_i) begin
        // [R6] Factory defaults
        if (!rstn_i || cmd_fac) begin
            volt_q <= 1'b0;
            inv_q  <= 1'b0;
            mode_q <= MD_SINGLE;
            pt1_q  <= PT1_RST;
            pt2_q  <= PT2_RST;
            hyst_q <= HYST_RST;
        end else begin
            if (w_ctrl) begin
                // [R13] Output form select
                volt_q <= hwdata_i[CB_VOLT];
                // [R14] Characteristic inversion
                inv_q  <= hwdata_i[CB_INV];
                // [R19] Mode write gated
                if (mode_ok)
                    mode_q <= pstl_mode_e'(wmode);
            end
            if (w_pt1)
                pt1_q <= wd16;
            if (w_pt2)
                pt2_q <= wd16;
            // [R20] Out-of-range value ignored
            if (w_hyst && hyst_ok)
                hyst_q <= wd16;
        end
    end

    // Measuring range
    always_ff @(posedge clk_i) begin
        // [R12] Full span restore
        if (!rstn_i || cmd_fac || cmd_rr) begin
            start_q <= 16'h0000;
            end_q   <= FULL_SPAN;
        end else if (commit) begin
            start_q <= tstart_q;
            end_q   <= pos_i;
        end
    end

    // Position relative to range
    assign mag_in = mag_ok_i && (pos_i >= start_q) && (pos_i <= end_q);
    wire [15:0] rel    = pos_i - start_q;
    wire [15:0] span   = end_q - start_q;
    wire [16:0] rel17  = {1'b0, rel};
    wire        valid  = mag_in & ~hold_q;

    // [R21] Startup hold until full stroke, released at once if in range on the first cycle
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            hold_q    <= 1'b1;
            first_q   <= 1'b1;
            seen_lo_q <= 1'b0;
            seen_hi_q <= 1'b0;
        end else begin
            first_q <= 1'b0;
            if (mag_ok_i && pos_i <= start_q)
                seen_lo_q <= 1'b1;
            if (mag_ok_i && pos_i >= end_q)
                seen_hi_q <= 1'b1;
            if ((first_q && mag_in) || (seen_lo_q && seen_hi_q))
                hold_q <= 1'b0;
        end
    end

    // Band limits shared by window and auto modes
    wire [15:0] pt_lo  = (pt1_q < pt2_q) ? pt1_q : pt2_q;
    wire [15:0] pt_hi  = (pt1_q < pt2_q) ? pt2_q : pt1_q;
    wire [16:0] h15    = {1'b0, hyst_q} + {2'b00, hyst_q[15:1]};
    wire [16:0] band17 = {1'b0, AUTO_BAND};
    wire        is_auto = (mode_q == MD_AUTO);
    // [R17] Auto band and margin check
    wire        auto_ok = ({1'b0, pt1_q} >= band17 + h15) &&
                          ({1'b0, pt1_q} + band17 + h15 < {1'b0, span});
    wire [15:0] b_lo = is_auto ? sub_sat(pt1_q, AUTO_BAND) : pt_lo;
    wire [16:0] b_hi = is_auto ? {1'b0, pt1_q} + band17 : {1'b0, pt_hi};
    // [R24] Window with hysteresis at edges
    wire        win_on   = (rel >= b_lo) && (rel17 <= b_hi);
    wire        win_keep = (rel >= sub_sat(b_lo, hyst_q)) &&
                           (rel17 <= b_hi + {1'b0, hyst_q});

    // [R15] Mode evaluation
    always_comb begin
        case (mode_q)
            // [R23] Set at point, clear below
            MD_SINGLE: sw_eval = sw_q ? (rel >= sub_sat(pt1_q, hyst_q))
                                      : (rel >= pt1_q);
            MD_AUTO:   sw_eval = auto_ok & (sw_q ? win_keep : win_on);
            MD_WINDOW: sw_eval = sw_q ? win_keep : win_on;
            // [R19] Two point runs without link
            default:   sw_eval = sw_q ? (rel > pt_lo) : (rel >= pt_hi);
        endcase
    end

    // [R5] Analogue inactive in link mode
    assign ana_d.active = ~serial_q;
    assign ana_d.volt   = volt_q;
    // [R14] Inverted or direct code, floor when invalid
    assign ana_d.code   = !valid ? 16'h0000 : (inv_q ? span - rel : rel);

    // Output stages
    always_ff @(posedge clk_i) begin
        // [R6] Switch low after reset
        if (!rstn_i) begin
            sw_q  <= 1'b0;
            ana_o <= '0;
            led_o <= '0;
            pad_q <= 1'b0;
        end else begin
            // [R21] Low while holding
            sw_q  <= valid & sw_eval;
            ana_o <= ana_d;
            led_o <= led_d;
            pad_q <= pad_s;
        end
    end
    assign sw_o = sw_q;

    // Pad edges
    wire pad_rise = pad_s & ~pad_q;
    wire pad_fall = ~pad_s & pad_q;
    // [R11] Span against minimum
    wire short = {1'b0, pos_i} < {1'b0, tstart_q} + {1'b0, MIN_SPAN};

    // Teach sequencer
    always_comb begin
        tst_d   = tst_q;
        tmr_d   = tmr_q + TMR_W'(1);
        load_st = 1'b0;
        commit  = 1'b0;
        abort   = 1'b0;
        case (tst_q)
            TS_IDLE: if (pad_rise) begin
                tst_d = TS_PRESS;
                tmr_d = '0;
            end
            TS_PRESS: if (pad_fall) begin
                tst_d = TS_GAP;
                tmr_d = '0;
            end else if (tmr_q >= CLICK_W) begin
                tst_d = TS_IDLE;
            end
            TS_GAP: if (pad_rise) begin
                tst_d = TS_HOLD;
                tmr_d = '0;
            end else if (tmr_q >= CLICK_W) begin
                tst_d = TS_IDLE;
            end
            // [R7] Held second press enters level one
            TS_HOLD: if (pad_fall) begin
                tst_d = TS_IDLE;
            end else if (tmr_q >= HOLD_W) begin
                tst_d = TS_LVL1;
            end
            // [R10] Start without magnet aborts
            TS_LVL1: if (pad_rise) begin
                load_st = mag_ok_i;
                abort   = ~mag_ok_i;
                tst_d   = mag_ok_i ? TS_LVL2 : TS_IDLE;
            end
            // [R9] End taken, acknowledged
            TS_LVL2: if (pad_rise | cmd_te) begin
                tst_d  = TS_IDLE;
                abort  = ~mag_ok_i | short;
                commit = mag_ok_i & ~short;
            end
            default: tst_d = TS_IDLE;
        endcase
        if (cmd_ts) begin
            tst_d   = mag_ok_i ? TS_LVL2 : TS_IDLE;
            load_st = mag_ok_i;
            abort   = ~mag_ok_i;
            commit  = 1'b0;
        end
    end

    // Teach state, timer, captured start, blink count
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            tst_q     <= TS_IDLE;
            tmr_q     <= '0;
            tstart_q  <= 16'h0000;
            ack_cnt_q <= 3'h0;
            ack_org_q <= 1'b0;
        end else begin
            tst_q <= tst_d;
            tmr_q <= tmr_d;
            if (load_st)
                tstart_q <= pos_i;
            // [R10] Four orange blinks on abort
            if (commit | abort) begin
                ack_cnt_q <= ACK_BLINKS;
                ack_org_q <= abort;
            end else if (ack_fall) begin
                ack_cnt_q <= ack_cnt_q - 3'h1;
            end
        end
    end

    // [R1] Error blink generator
    pstl_blink #(.HALF(ERR_HALF)) u_err (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .run_i   (~ready_i | field_weak_i),
        .blink_o (err_bl),
        .fall_o  ()
    );
    pstl_blink #(.HALF(SLOW_HALF)) u_slow (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .run_i   ((tst_q == TS_LVL1) | (tst_q == TS_LVL2)),
        .blink_o (slow_bl),
        .fall_o  ()
    );
    pstl_blink #(.HALF(ACK_HALF)) u_ack (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .run_i   (ack_cnt_q != 3'h0),
        .blink_o (ack_bl),
        .fall_o  (ack_fall)
    );

    // Indicator mapping
    assign led_d.link   = serial_q;
    assign led_d.cur    = ~serial_q & ~volt_q;
    assign led_d.volt   = ~serial_q & volt_q;
    assign led_d.err    = err_bl;
    // [R2] Overload shown apart from high and low
    assign led_d.high   = sw_q & ~ovc_s;
    assign led_d.low    = ~sw_q & ~ovc_s;
    assign led_d.ovc    = ovc_s;
    // [R3] In range indication
    assign led_d.inr    = mag_in;
    // [R4] Out of range indication
    assign led_d.outr   = ~mag_in;
    assign led_d.teach  = slow_bl | (ack_bl & ~ack_org_q);
    assign led_d.orange = ack_bl & ack_org_q;

    property p_ana_off;
        @(posedge clk_i) disable iff (!rstn_i)
        serial_q [*2] |-> !ana_o.active && !led_o.cur && !led_o.volt;
    endproperty
    a_ana_off: assert property (p_ana_off) // [R5]
        else $error("analogue active in link mode");

    property p_err_dark;
        @(posedge clk_i) disable iff (!rstn_i)
        (ready_i && !field_weak_i) [*3] |-> !led_o.err;
    endproperty
    a_err_dark: assert property (p_err_dark) // [R1]
        else $error("error led lit without fault");

    property p_ovc;
        @(posedge clk_i) disable iff (!rstn_i)
        ovc_s |=> led_o.ovc && !led_o.high && !led_o.low;
    endproperty
    a_ovc: assert property (p_ovc) // [R2]
        else $error("overcurrent not indicated");

    property p_out_range;
        @(posedge clk_i) disable iff (!rstn_i)
        !mag_in |=> led_o.outr && !led_o.inr && !sw_q;
    endproperty
    a_out_range: assert property (p_out_range) // [R4]
        else $error("outside range not shown");

    property p_level1;
        @(posedge clk_i) disable iff (!rstn_i)
        (tst_q == TS_HOLD) && !pad_fall && (tmr_q >= HOLD_W) && !cmd_ts
        |=> (tst_q == TS_LVL1);
    endproperty
    a_level1: assert property (p_level1) // [R7]
        else $error("teach level one not entered");

    property p_ack;
        @(posedge clk_i) disable iff (!rstn_i)
        commit |=> (ack_cnt_q == ACK_BLINKS) && !ack_org_q &&
                   (end_q == $past(pos_i));
    endproperty
    a_ack: assert property (p_ack) // [R9]
        else $error("teach completion not acknowledged");

    property p_abort;
        @(posedge clk_i) disable iff (!rstn_i)
        (tst_q == TS_LVL2) && pad_rise && !mag_ok_i
        |=> ack_org_q && (ack_cnt_q == ACK_BLINKS) && (tst_q == TS_IDLE);
    endproperty
    a_abort: assert property (p_abort) // [R10]
        else $error("missing magnet did not abort");

    property p_span;
        @(posedge clk_i) disable iff (!rstn_i)
        commit |-> {1'b0, pos_i} >= {1'b0, tstart_q} + {1'b0, MIN_SPAN};
    endproperty
    a_span: assert property (p_span) // [R11]
        else $error("short range accepted");

    property p_range_rst;
        @(posedge clk_i) disable iff (!rstn_i)
        cmd_rr |=> (start_q == 16'h0000) && (end_q == FULL_SPAN);
    endproperty
    a_range_rst: assert property (p_range_rst) // [R12]
        else $error("range reset failed");

    property p_two_pt;
        @(posedge clk_i) disable iff (!rstn_i)
        w_ctrl && !mode_ok && !cmd_fac |=> mode_q == $past(mode_q);
    endproperty
    a_two_pt: assert property (p_two_pt) // [R19]
        else $error("two point set without link");

    property p_hyst;
        @(posedge clk_i) disable iff (!rstn_i)
        (hyst_q >= HYST_MIN) && (hyst_q <= HYST_MAX);
    endproperty
    a_hyst: assert property (p_hyst) // [R20]
        else $error("hysteresis out of limits");

    property p_hold;
        @(posedge clk_i) disable iff (!rstn_i)
        hold_q |=> !sw_q && (ana_o.code == 16'h0000);
    endproperty
    a_hold: assert property (p_hold) // [R21]
        else $error("outputs not low during startup hold");

    property p_single;
        @(posedge clk_i) disable iff (!rstn_i)
        (mode_q == MD_SINGLE) && valid && (rel >= pt1_q) |=> sw_q;
    endproperty
    a_single: assert property (p_single) // [R23]
        else $error("single point did not set");
endmodule : pstl_top

// File: pstl_top_tb.sv
`timescale 1ns/1ns
module pstl_top_tb
    import pstl_pkg::*;
;
    logic        clk_i, rstn_i, hwrite, mag, rdy, ovc, hrdy, sw, m_sw, pv;
    logic        pad, fw, hresp;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    logic [15:0] pos, m_code;
    pstl_ana_s   ana;
    pstl_led_s   led;
    int          n_mismatch, compares, cyc, n;

    pstl_top #(.ERR_HALF(4), .SLOW_HALF(4), .ACK_HALF(4), .CLICK_MAX(20),
        .HOLD_MIN(40)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(1'h1),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
        .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .pos_i(pos),
        .mag_ok_i(mag), .ready_i(rdy), .field_weak_i(fw), .pad_i(pad),
        .ovc_i(ovc), .sw_o(sw), .ana_o(ana), .led_o(led));
    pstl_ctrl_model mdl (.clk_i(clk_i), .rstn_i(rstn_i), .sw_i(sw),
        .ana_i(ana), .sw_o(m_sw), .code_o(m_code));

    // Clock
    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    // Hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task end_sim;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask : tick

    // One AHB single transfer
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk_i); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_i); while (hrdy !== 1'b1);
        q = hrdata;
    endtask : bus

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
        tick(2);
    endtask : wr

    task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(nm, e, q);
    endtask : rc

    task sp(input logic [15:0] p, input logic e);
        pos <= p;
        tick(3);
        chk("sw", {31'h0, e}, {31'h0, sw});
        chk("model sw", {31'h0, e}, {31'h0, m_sw});
    endtask : sp

    // Pad click, then 5 cycles released, inside the click window
    task pc(input int k);
        pad <= 1'h1;
        tick(k);
        pad <= 1'h0;
        tick(5);
    endtask : pc

    // Main sequence
    initial begin
        rstn_i = 0; htrans = 0; haddr = 0; hwrite = 0; hwdata = 0; cyc = 0;
        pos = 16'h0200; mag = 1; rdy = 1; ovc = 0; pad = 0; fw = 0;
        tick(20);
        rstn_i <= 1'h1;
        rc("ctrl", REG_CTRL, 32'h0);
        rc("rend", REG_REND, {16'h0, SPAN_RST});
        rc("hyst", REG_HYST, 32'h32);
        rc("unmapped", 8'h40, 32'h0);
        chk("sw", 32'h0, {31'h0, sw});
        chk("ana", {14'h0, 2'h2, 16'h0200}, ana);
        chk("inr", 32'h1, {31'h0, led.inr});
        chk("led", 32'h228, led);
        chk("hresp", 32'h0, {31'h0, hresp});
        wr(REG_HYST, 32'h7D1);
        rc("hyst", REG_HYST, 32'h32);
        wr(REG_HYST, 32'h5);
        rc("hyst", REG_HYST, 32'h5);
        wr(REG_HYST, 32'h32);
        sp(16'h03E8, 1'h1);
        sp(16'h03B6, 1'h1);
        sp(16'h03B5, 1'h0);
        wr(REG_CTRL, 32'h3);
        chk("ana", {14'h0, 2'h3, SPAN_RST - 16'h03B5}, ana);
        wr(REG_CTRL, 32'h10);
        tick(20);
        chk("active", 32'h0, {31'h0, ana.active});
        chk("model", 32'h0, {16'h0, m_code});
        wr(REG_CTRL, 32'h1C);
        rc("ctrl", REG_CTRL, 32'h1C);
        wr(REG_CTRL, 32'h8);
        wr(REG_CTRL, 32'hC);
        rc("ctrl", REG_CTRL, 32'h8);
        sp(16'h0600, 1'h1);
        sp(16'h07E0, 1'h1);
        sp(16'h0803, 1'h0);
        wr(REG_CTRL, 32'h4);
        sp(16'h0460, 1'h1);
        sp(16'h0600, 1'h0);
        wr(REG_CTRL, 32'h0);
        pos <= 16'h0100;
        wr(REG_CTRL, 32'h400);
        pos <= 16'h0150;
        wr(REG_CTRL, 32'h800);
        rc("rend", REG_REND, {16'h0, SPAN_RST});
        wr(REG_CTRL, 32'h400);
        pos <= 16'h0300;
        wr(REG_CTRL, 32'h800);
        rc("rend", REG_REND, 32'h300);
        mag <= 1'h0;
        wr(REG_CTRL, 32'h400);
        rc("rstart", REG_RSTART, 32'h150);
        mag <= 1'h1;
        pc(5);
        pc(50);
        bus(1'h0, REG_STAT, 32'h0);
        chk("teach", 32'h4, q[7:5]);
        pc(5);
        mag <= 1'h0;
        pc(5);
        rc("rstart", REG_RSTART, 32'h150);
        mag <= 1'h1;
        wr(REG_CTRL, 32'h100);
        rc("rend", REG_REND, {16'h0, SPAN_RST});
        rc("rstart", REG_RSTART, 32'h0);
        pos <= 16'h3000;
        tick(3);
        chk("outr", 32'h1, {30'h0, led.inr, led.outr});
        chk("code", 32'h0, {16'h0, ana.code});
        ovc <= 1'h1;
        tick(5);
        chk("ovc", 32'h1, {31'h0, led.ovc});
        fw <= 1'h1;
        repeat (2) begin
            tick(6);
            n = 0;
            pv = led.err;
            repeat (16) begin
                tick(1);
                if (led.err !== pv) n++;
                pv = led.err;
            end
            chk("err toggles", 32'h4, n);
            fw <= 1'h0;
            rdy <= 1'h0;
        end
        end_sim();
    end
endmodule : pstl_top_tb
